/* verilog/oct_regs.svh */
/*
 constants of the output terminal conditioner: timing, codes, reset values.
 assumes a 40 MHz system clock and codes in 0.1 % steps (1000 = 100 %).
*/
// Operation
// - output turns active only after its turn-on delay has elapsed
// - in level mode, output turns inactive only after its turn-off delay has elapsed
// - a delay of zero disables that delay
// - each digital output has a pulse width, 0 to 32767 ms, reset 250 ms
// - single pulse holds active exactly the configured width, then drops
// - level mode tracks status; pulse mode pulses once on enable
// - each analog channel and pulse output has its own source selector
// - type setting 1 turns second transistor output into frequency pulses
// - selections 0 and 1 scale running or set frequency to max frequency
// - selections 2 and 3 scale torque 0 to 200 % onto full code
// - selection 4 scales current up to twice rated current
// - selection 5 scales voltage up to 1.5 times rated voltage
// - selection 6 scales bus voltage 0 to 1000 V
// - selection 7 scales power up to twice rated power
// - selections 8 to 11 report raw analog input voltage
// - selection 12 scales pulse input frequency across its range
// - selections 14 and 15 scale count or length into output range
// - analog result is gain times scaled value plus offset
// - full code means 10 V or 20 mA depending on range
`ifndef OCT_REGS_SVH
`define OCT_REGS_SVH
`define OCT_CLK_PERIOD_NS 25
`define OCT_MS_NS 1000000
`define OCT_FULL_CODE 10'h03e8
`define OCT_PULSE_MS_RST 15'h00fa
`define OCT_DELAY_MS_RST 15'h0000
`define OCT_GAIN_RST 11'h064
`define OCT_GAIN_DIV 32'h0000_0064
`define OCT_OFFSET_RST 11'h000
`define OCT_SEL_A_RST 4'h0
`define OCT_SEL_B_RST 4'h2
`define OCT_SEL_P_RST 4'hb
`define OCT_TYPE_PULSE 1'h1
`define OCT_TORQUE_FULL 32'h0000_07d0
`define OCT_BUS_FULL 32'h0000_03e8
`define OCT_AIN_FULL 32'h0000_03e8
`endif

/* verilog/oct_pkg.sv */
/*
 types of the output terminal conditioner.
 assumes measurements arrive already in fixed units from the drive core.
*/
`default_nettype none
package oct_pkg;
    typedef struct packed {
        logic pulse_mode;
        logic [14:0] on_ms;
        logic [14:0] off_ms;
        logic [14:0] pulse_ms;
    } oct_dout_cfg_type;
    typedef struct packed {
        logic [3:0] sel;
        logic signed [10:0] gain;
        logic signed [10:0] offset;
    } oct_chan_cfg_type;
    typedef struct packed {
        logic signed [15:0] run_freq;
        logic signed [15:0] set_freq;
        logic signed [15:0] out_torque;
        logic signed [15:0] set_torque;
        logic [15:0] current;
        logic [15:0] voltage;
        logic [15:0] bus_volt;
        logic [15:0] power;
        logic [3:0][15:0] ain;
        logic [15:0] pulse_freq;
        logic [15:0] count;
        logic [15:0] length;
    } oct_meas_type;
    typedef struct packed {
        logic [15:0] max_freq;
        logic [15:0] rated_current;
        logic [15:0] rated_voltage;
        logic [15:0] rated_power;
        logic [15:0] pin_lo;
        logic [15:0] pin_hi;
        logic [15:0] count_limit;
        logic [9:0] out_lo;
        logic [9:0] out_hi;
    } oct_ref_type;
    typedef enum logic [3:0] {
        OCT_SEL_RUN_FREQ, OCT_SEL_SET_FREQ, OCT_SEL_OUT_TQ, OCT_SEL_SET_TQ,
        OCT_SEL_CURRENT, OCT_SEL_VOLTAGE, OCT_SEL_BUS, OCT_SEL_POWER,
        OCT_SEL_AIN1, OCT_SEL_AIN2, OCT_SEL_AIN3, OCT_SEL_AIN4,
        OCT_SEL_PULSE_IN, OCT_SEL_SPARE, OCT_SEL_COUNT, OCT_SEL_LENGTH
    } oct_sel_type;
endpackage : oct_pkg
`default_nettype wire

/* verilog/oct_dout_cond.sv */
/*
 one digital output: turn-on/turn-off delay and single pulse.
 assumes the function status is synchronous to clk.
*/
`default_nettype none
`include "oct_regs.svh"
module oct_dout_cond #(
    parameter int MS_CYCLES = `OCT_MS_NS / `OCT_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // function side
    input wire logic func_status,
    input wire oct_pkg::oct_dout_cfg_type cfg,
    // terminal side
    output logic level_out
);
    import oct_pkg::*;
    localparam logic [15:0] SUB_LAST = 16'(MS_CYCLES - 1);
    typedef struct packed {
        logic lvl;
        logic pact;
        logic out;
        logic [15:0] dsub;
        logic [14:0] dms;
        logic [15:0] psub;
        logic [14:0] pms;
    } oct_dout_state_type;
    oct_dout_state_type st_reg;
    oct_dout_state_type st_next;
    logic [14:0] dly;

    always_comb begin
        st_next = st_reg;
        dly = func_status ? cfg.on_ms : cfg.off_ms;
        if (func_status == st_reg.lvl) begin
            // reverting drops the pending change
            st_next.dsub = '0;
            st_next.dms = '0;
        end else if (st_reg.dms >= dly) begin
            // whole ms counted; >= covers a delay shortened mid-count
            st_next.lvl = func_status;
            st_next.dsub = '0;
            st_next.dms = '0;
        end else if (st_reg.dsub == SUB_LAST) begin
            st_next.dsub = '0;
            st_next.dms = st_reg.dms + 15'h0001;
        end else begin
            st_next.dsub = st_reg.dsub + 16'h0001;
        end
        // a retrigger during a pulse restarts the width
        if (st_next.lvl && !st_reg.lvl && cfg.pulse_ms != 15'h0000) begin
            st_next.pact = 1'b1;
            st_next.psub = '0;
            st_next.pms = '0;
        end else if (st_reg.pact) begin
            if (st_reg.psub == SUB_LAST &&
                st_reg.pms == cfg.pulse_ms - 15'h0001) begin
                st_next.pact = 1'b0;
            end else if (st_reg.psub == SUB_LAST) begin
                st_next.psub = '0;
                st_next.pms = st_reg.pms + 15'h0001;
            end else begin
                st_next.psub = st_reg.psub + 16'h0001;
            end
        end
        st_next.out = cfg.pulse_mode ? st_next.pact : st_next.lvl;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign level_out = st_reg.out;

    rise_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(st_reg.lvl) |-> $past(func_status))
        else $error("level rose without active status");
    fall_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(st_reg.lvl) |-> !$past(func_status))
        else $error("level fell without inactive status");
    zero_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
        (func_status && !st_reg.lvl && cfg.on_ms == 15'h0000) |=> st_reg.lvl)
        else $error("zero turn-on delay still waited");
    revert_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (func_status == st_reg.lvl) |=> $stable(st_reg.lvl))
        else $error("level changed with no pending change");
    pulse_width_a: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(st_reg.pact) |->
        $past(st_reg.pms) == $past(cfg.pulse_ms) - 15'h0001)
        else $error("pulse ended at the wrong width");
    level_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(cfg.pulse_mode) |-> level_out == st_reg.lvl)
        else $error("level mode output differs from status");
endmodule : oct_dout_cond
`default_nettype wire

/* verilog/oct_gain_offset.sv */
/*
 per-channel gain and offset with saturation to the full code.
 assumes gain in 0.01 steps and offset in 0.1 % steps, both signed.
*/
`default_nettype none
`include "oct_regs.svh"
module oct_gain_offset (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // scaled value and settings
    input wire logic [9:0] x,
    input wire oct_pkg::oct_chan_cfg_type cfg,
    // converter code
    output logic [9:0] y
);
    import oct_pkg::*;
    typedef struct packed {
        logic [9:0] y;
    } oct_go_state_type;
    oct_go_state_type st_reg;
    oct_go_state_type st_next;
    logic signed [31:0] mix;

    always_comb begin
        st_next = st_reg;
        mix = $signed({22'h00_0000, x}) * 32'($signed(cfg.gain));
        mix = mix / $signed(`OCT_GAIN_DIV) +
              32'($signed(cfg.offset));
        if (mix < 0) begin
            st_next.y = '0;
        end else if (mix > $signed({22'h00_0000, `OCT_FULL_CODE})) begin
            st_next.y = `OCT_FULL_CODE;
        end else begin
            st_next.y = mix[9:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign y = st_reg.y;

    unity_gain_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.gain == 11'sh064 && cfg.offset == 11'sh000 &&
         x <= `OCT_FULL_CODE) |=> y == $past(x))
        else $error("unity gain did not pass value through");
    sat_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        y <= `OCT_FULL_CODE)
        else $error("converter code above full scale");
endmodule : oct_gain_offset
`default_nettype wire

/* verilog/oct_top.sv */
/*
 output terminal conditioner: two transistor and two relay outputs with
 delays and pulses, two analog channels and a frequency pulse output.
 assumes all inputs synchronous to clk; settings held by the drive core.
*/
`default_nettype none
`include "oct_regs.svh"
module oct_top #(
    parameter int MS_CYCLES = `OCT_MS_NS / `OCT_CLK_PERIOD_NS,
    parameter int PULSE_FMAX_HZ = 50000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // function status, bit 0..3 = transistor a, b, relay a, b
    input wire logic [3:0] func_status,
    input wire oct_pkg::oct_dout_cfg_type dout_cfg [4],
    input wire logic out_b_type_select,
    // analog channel and pulse output settings
    input wire oct_pkg::oct_chan_cfg_type analog_a_cfg,
    input wire oct_pkg::oct_chan_cfg_type analog_b_cfg,
    input wire logic [3:0] pulse_source_select,
    input wire logic range_current_a,
    input wire logic range_current_b,
    // measured quantities and their references
    input wire oct_pkg::oct_meas_type meas,
    input wire oct_pkg::oct_ref_type refs,
    // terminal drivers
    output logic transistor_out_a,
    output logic transistor_out_b,
    output logic relay_out_a,
    output logic relay_out_b,
    // converter stage
    output logic [9:0] analog_out_a,
    output logic [9:0] analog_out_b,
    output logic dac_current_a,
    output logic dac_current_b
);
    import oct_pkg::*;

    // phase step per code; at most a few million, so 32 bits suffice
    localparam logic [63:0] INC_PER_CODE =
        ((64'(PULSE_FMAX_HZ) * 64'(`OCT_CLK_PERIOD_NS)) << 32) /
        (64'(`OCT_FULL_CODE) * 64'd1000000000);

    typedef struct packed {
        logic [3:0] dout;
        logic tb_pin;
        logic [9:0] xa;
        logic [9:0] xb;
        logic [9:0] xp;
        logic [31:0] acc;
        logic cur_a;
        logic cur_b;
    } oct_top_state_type;
    oct_top_state_type st_reg;
    oct_top_state_type st_next;
    logic [3:0] lvl;

    function automatic logic [15:0] oct_abs(input logic signed [15:0] v);
        oct_abs = v[15] ? 16'(-v) : 16'(v);
    endfunction : oct_abs

    // v over full, in 0.1 % steps, clipped at full code
    function automatic logic [9:0] oct_scale(input logic [31:0] v,
                                             input logic [31:0] full);
        logic [31:0] q;
        q = '0;
        if (full != 32'h0000_0000) begin
            q = (v * 32'(`OCT_FULL_CODE)) / full;
        end
        oct_scale = (q > 32'(`OCT_FULL_CODE)) ? `OCT_FULL_CODE : q[9:0];
    endfunction : oct_scale

    // count or length mapped from 0..limit into out_lo..out_hi
    function automatic logic [9:0] oct_span(input logic [15:0] v,
                                            input oct_ref_type r);
        logic [31:0] s;
        logic [31:0] w;
        s = 32'(oct_scale(32'(v), 32'(r.count_limit)));
        w = '0;
        if (r.out_hi > r.out_lo) begin
            w = 32'(r.out_hi - r.out_lo);
        end
        s = 32'(r.out_lo) + (s * w) / 32'(`OCT_FULL_CODE);
        oct_span = (s > 32'(`OCT_FULL_CODE)) ? `OCT_FULL_CODE : s[9:0];
    endfunction : oct_span

    function automatic logic [9:0] oct_select(input logic [3:0] sel,
                                              input oct_meas_type m,
                                              input oct_ref_type r);
        logic [9:0] res;
        res = '0;
        case (oct_sel_type'(sel))
            OCT_SEL_RUN_FREQ: begin
                res = oct_scale(32'(oct_abs(m.run_freq)),
                                32'(r.max_freq));
            end
            OCT_SEL_SET_FREQ: begin
                res = oct_scale(32'(oct_abs(m.set_freq)),
                                32'(r.max_freq));
            end
            OCT_SEL_OUT_TQ: begin
                res = oct_scale(32'(oct_abs(m.out_torque)),
                                `OCT_TORQUE_FULL);
            end
            OCT_SEL_SET_TQ: begin
                res = oct_scale(32'(oct_abs(m.set_torque)),
                                `OCT_TORQUE_FULL);
            end
            OCT_SEL_CURRENT: begin
                res = oct_scale(32'(m.current),
                                32'(r.rated_current) << 1);
            end
            OCT_SEL_VOLTAGE: begin
                res = oct_scale(32'(m.voltage),
                                (32'(r.rated_voltage) * 32'd3) >> 1);
            end
            OCT_SEL_BUS: begin
                res = oct_scale(32'(m.bus_volt), `OCT_BUS_FULL);
            end
            OCT_SEL_POWER: begin
                res = oct_scale(32'(m.power),
                                32'(r.rated_power) << 1);
            end
            OCT_SEL_AIN1, OCT_SEL_AIN2, OCT_SEL_AIN3, OCT_SEL_AIN4: begin
                // raw input, taken ahead of any offset correction
                res = oct_scale(32'(m.ain[sel[1:0]]),
                                `OCT_AIN_FULL);
            end
            OCT_SEL_PULSE_IN: begin
                if (m.pulse_freq > r.pin_lo && r.pin_hi > r.pin_lo) begin
                    res = oct_scale(32'(m.pulse_freq - r.pin_lo),
                                    32'(r.pin_hi - r.pin_lo));
                end
            end
            OCT_SEL_COUNT: begin
                res = oct_span(m.count, r);
            end
            OCT_SEL_LENGTH: begin
                res = oct_span(m.length, r);
            end
            default: begin
                res = '0;
            end
        endcase
        oct_select = res;
    endfunction : oct_select

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dout
            oct_dout_cond #(
                .MS_CYCLES(MS_CYCLES)
            ) u_dout (
                .clk(clk),
                .rst_n(rst_n),
                .func_status(func_status[gi]),
                .cfg(dout_cfg[gi]),
                .level_out(lvl[gi])
            );
        end
    endgenerate

    oct_gain_offset u_go_a (
        .clk(clk),
        .rst_n(rst_n),
        .x(st_reg.xa),
        .cfg(analog_a_cfg),
        .y(analog_out_a)
    );

    oct_gain_offset u_go_b (
        .clk(clk),
        .rst_n(rst_n),
        .x(st_reg.xb),
        .cfg(analog_b_cfg),
        .y(analog_out_b)
    );

    always_comb begin
        st_next = st_reg;
        st_next.dout = lvl;
        // each consumer has its own source selector
        st_next.xa = oct_select(analog_a_cfg.sel, meas, refs);
        st_next.xb = oct_select(analog_b_cfg.sel, meas, refs);
        st_next.xp = oct_select(pulse_source_select, meas, refs);
        // phase accumulator: msb toggles at code/1000 of the top rate
        st_next.acc = st_reg.acc + 32'(64'(st_reg.xp) * INC_PER_CODE);
        if (out_b_type_select == `OCT_TYPE_PULSE) begin
            st_next.tb_pin = st_next.acc[31];
        end else begin
            st_next.tb_pin = lvl[1];
        end
        // range follows the converter switch; code meaning is unchanged
        st_next.cur_a = range_current_a;
        st_next.cur_b = range_current_b;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign transistor_out_a = st_reg.dout[0];
    assign transistor_out_b = st_reg.tb_pin;
    assign relay_out_a = st_reg.dout[2];
    assign relay_out_b = st_reg.dout[3];
    assign dac_current_a = st_reg.cur_a;
    assign dac_current_b = st_reg.cur_b;

    pulse_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(out_b_type_select) |-> transistor_out_b == st_reg.acc[31])
        else $error("pulse output not taken from accumulator");
    level_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(out_b_type_select) |-> transistor_out_b == $past(lvl[1]))
        else $error("level output b not following status");
    freq_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        (analog_a_cfg.sel == 4'h0 && refs.max_freq != 16'h0000 &&
         oct_abs(meas.run_freq) >= refs.max_freq) |=>
        st_reg.xa == `OCT_FULL_CODE)
        else $error("max frequency not at full code");
    torque_half_a: assert property (@(posedge clk) disable iff (!rst_n)
        (analog_a_cfg.sel == 4'h2 && meas.out_torque == 16'sh03e8) |=>
        st_reg.xa == 10'h01f4)
        else $error("100 percent torque not at half code");
    bus_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        (analog_b_cfg.sel == 4'h6 && meas.bus_volt == 16'h03e8) |=>
        st_reg.xb == `OCT_FULL_CODE)
        else $error("1000 V bus not at full code");
endmodule : oct_top
`default_nettype wire

/* tb/oct_term_model.sv */
/*
 terminal driver model: turns converter codes into milli-units at the pin.
 assumes codes of 0 to 1000 and a range bit from the conditioner.
*/
`default_nettype none
module oct_term_model (
    // converter side
    input wire logic [9:0] code,
    input wire logic current_range,
    // pin level, mV in voltage range, uA in current range
    output var int level_milli
);
    timeunit 1ns;
    timeprecision 1ps;
    // overrange headroom of the real stage is not modelled
    assign level_milli = current_range ? int'(code) * 20 : int'(code) * 10;
endmodule : oct_term_model
`default_nettype wire

/* tb/oct_top_bench.sv */
/*
 bench of the output terminal conditioner: delays, single pulse, analog
 scaling and the frequency pulse output.
 assumes oct_pkg, oct_top and oct_term_model; one ms is 4 clocks here.
*/
`default_nettype none
module oct_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import oct_pkg::*;
    localparam int MS = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] func_status = 4'h0;
    oct_dout_cfg_type dout_cfg [4];
    logic out_b_type_select = 1'b0;
    oct_chan_cfg_type cfg_a, cfg_b;
    logic [3:0] pulse_source_select = 4'h6;
    logic range_a = 1'b0;
    logic range_b = 1'b0;
    oct_meas_type meas;
    oct_ref_type refs;
    logic [3:0] outs;
    logic [9:0] code_a, code_b;
    logic dac_a, dac_b;
    int level_a;
    int seed = 32'h86f6;
    int num_errors = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    oct_top #(.MS_CYCLES(MS)) DUT (
        .clk(clk), .rst_n(rst_n), .func_status(func_status),
        .dout_cfg(dout_cfg), .out_b_type_select(out_b_type_select),
        .analog_a_cfg(cfg_a), .analog_b_cfg(cfg_b),
        .pulse_source_select(pulse_source_select),
        .range_current_a(range_a), .range_current_b(range_b),
        .meas(meas), .refs(refs),
        .transistor_out_a(outs[0]), .transistor_out_b(outs[1]),
        .relay_out_a(outs[2]), .relay_out_b(outs[3]),
        .analog_out_a(code_a), .analog_out_b(code_b),
        .dac_current_a(dac_a), .dac_current_b(dac_b)
    );
    oct_term_model TERM (
        .code(code_a), .current_range(dac_a), .level_milli(level_a)
    );

    function automatic int rnd(input int hi);
        return int'($unsigned($random(seed)) % (hi + 1));
    endfunction : rnd

    function automatic int mag(input logic signed [15:0] v);
        return v < 0 ? -int'(v) : int'(v);
    endfunction : mag

    function automatic int span(input int v, input oct_ref_type r);
        return int'(r.out_lo) + (v * 1000 / int'(r.count_limit))
            * (int'(r.out_hi) - int'(r.out_lo)) / 1000;
    endfunction : span

    function automatic int scaled(input logic [3:0] s, input oct_meas_type m,
                                  input oct_ref_type r);
        case (s)
            4'h0: return mag(m.run_freq) * 1000 / int'(r.max_freq);
            4'h1: return mag(m.set_freq) * 1000 / int'(r.max_freq);
            4'h2: return mag(m.out_torque) * 1000 / 2000;
            4'h3: return mag(m.set_torque) * 1000 / 2000;
            4'h4: return int'(m.current) * 500 / int'(r.rated_current);
            4'h5: return int'(m.voltage) * 1000
                / (int'(r.rated_voltage) * 3 / 2);
            4'h6: return int'(m.bus_volt);
            4'h7: return int'(m.power) * 500 / int'(r.rated_power);
            4'hc: begin
                if (m.pulse_freq <= r.pin_lo) return 0;
                return int'(m.pulse_freq - r.pin_lo) * 1000
                    / int'(r.pin_hi - r.pin_lo);
            end
            4'hd: return 0;
            4'he: return span(int'(m.count), r);
            4'hf: return span(int'(m.length), r);
            default: return int'(m.ain[s[1:0]]);
        endcase
    endfunction : scaled

    function automatic int final_code(input int x, input oct_chan_cfg_type c);
        int y;
        y = int'(c.gain) * x / 100 + int'(c.offset);
        return y < 0 ? 0 : (y > 1000 ? 1000 : y);
    endfunction : final_code

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic settle(input int i, input logic lvl, output int n);
        n = 0;
        while (outs[i] !== lvl && n < 400) begin
            @(negedge clk);
            n++;
        end
    endtask : settle

    task automatic stays(input int i, input logic lvl, input int cyc);
        int bad;
        bad = 0;
        repeat (cyc) begin
            @(negedge clk);
            if (outs[i] !== lvl) bad++;
        end
        cmp(bad, 0);
    endtask : stays

    task automatic rand_meas();
        meas.run_freq = 16'(rnd(10000) - 5000);
        meas.set_freq = 16'(rnd(10000) - 5000);
        meas.out_torque = 16'(rnd(4000) - 2000);
        meas.set_torque = 16'(rnd(4000) - 2000);
        meas.current = 16'(rnd(600));
        meas.voltage = 16'(rnd(570));
        meas.bus_volt = 16'(rnd(1000));
        meas.power = 16'(rnd(1100));
        for (int j = 0; j < 4; j++) meas.ain[j] = 16'(rnd(1000));
        meas.pulse_freq = 16'(rnd(1100));
        meas.count = 16'(rnd(500));
        meas.length = 16'(rnd(500));
    endtask : rand_meas

    task automatic close_out();
        $display("checks %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        // far longer than the tests need, so only a hang trips it
        #1000000;
        num_errors++;
        close_out();
    end

    initial begin
        int n, ex_a, ex_b, rises;
        for (int i = 0; i < 4; i++) dout_cfg[i] = '0;
        cfg_a = '{sel: 4'h0, gain: 11'h064, offset: 11'h000};
        cfg_b = '{sel: 4'h2, gain: 11'h064, offset: 11'h000};
        refs = '{16'h1388, 16'h012c, 16'h017c, 16'h0226, 16'h0064,
                 16'h044c, 16'h01f4, 10'h064, 10'h384};
        meas = '0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            dout_cfg[i].on_ms = 15'(i);
            dout_cfg[i].off_ms = 15'(3 - i);
            func_status[i] = 1'b1;
            settle(i, 1'b1, n);
            cmp(n, i * MS + 2);
            func_status[i] = 1'b0;
            settle(i, 1'b0, n);
            cmp(n, (3 - i) * MS + 2);
        end
        func_status[3] = 1'b1;
        repeat (8) @(negedge clk);
        func_status[3] = 1'b0;
        stays(3, 1'b0, 30);
        func_status[2] = 1'b1;
        settle(2, 1'b1, n);
        func_status[2] = 1'b0;
        repeat (2) @(negedge clk);
        func_status[2] = 1'b1;
        stays(2, 1'b1, 20);
        $display("test delays done");
        dout_cfg[0] = '{1'b1, 15'h0001, 15'h0000, 15'(rnd(4) + 1)};
        func_status[0] = 1'b1;
        settle(0, 1'b1, n);
        cmp(n, MS + 2);
        settle(0, 1'b0, n);
        cmp(n, int'(dout_cfg[0].pulse_ms) * MS);
        stays(0, 1'b0, 30);
        func_status[0] = 1'b0;
        dout_cfg[0].pulse_ms = 15'h0000;
        repeat (10) @(negedge clk);
        func_status[0] = 1'b1;
        stays(0, 1'b0, 30);
        $display("test pulse done");
        for (int k = 0; k < 64; k++) begin
            rand_meas();
            cfg_a.sel = k < 16 ? 4'(k) : 4'(rnd(15));
            cfg_b.sel = 4'(rnd(15));
            cfg_a.gain = k % 3 == 0 ? 11'h064 : 11'(rnd(2000) - 1000);
            cfg_a.offset = k % 3 == 0 ? 11'h000 : 11'(rnd(2000) - 1000);
            cfg_b.gain = 11'(rnd(2000) - 1000);
            cfg_b.offset = 11'(rnd(400) - 200);
            range_a = 1'(rnd(1));
            range_b = 1'(rnd(1));
            ex_a = final_code(scaled(cfg_a.sel, meas, refs), cfg_a);
            ex_b = final_code(scaled(cfg_b.sel, meas, refs), cfg_b);
            repeat (3) @(negedge clk);
            cmp(code_a, ex_a);
            cmp(code_b, ex_b);
            cmp({dac_a, dac_b}, {range_a, range_b});
        end
        cfg_a = '{sel: 4'h6, gain: 11'h064, offset: 11'h000};
        meas.bus_volt = 16'h03e8;
        range_a = 1'b1;
        repeat (3) @(negedge clk);
        cmp(level_a, 32'h0000_4e20);
        $display("test analog done");
        out_b_type_select = 1'b1;
        pulse_source_select = 4'h6;
        rises = 0;
        repeat (4000) begin
            n = outs[1];
            @(negedge clk);
            if (n == 0 && outs[1] === 1'b1) rises++;
        end
        // full code is 50 kHz, 800 clocks a period
        cmp(rises >= 4 && rises <= 6, 1'b1);
        $display("test frequency output done");
        close_out();
    end
endmodule : oct_top_bench
`default_nettype wire
